/* File: shared/frcr_cfg.svh */
// Purpose: offsets, fields, reset values and codes of the rate/FIFO register bank
// Assumes: included by bare name wherever needed
// Notes: definitions only
`ifndef FRCR_CFG_SVH
`define FRCR_CFG_SVH
// ========================================
// register offsets
`define FRCR_ADR_CNT_LO 8'h22
`define FRCR_ADR_CNT_HI 8'h23
`define FRCR_ADR_FIFO 8'h24
`define FRCR_ADR_RATE 8'h42
`define FRCR_ADR_SCALE 8'h43
`define FRCR_ADR_DATA_LO 8'h12
`define FRCR_ADR_DATA_HI 8'h17
// ========================================
// reset values, masks, fields
`define FRCR_RATE_RST 8'h28
`define FRCR_SCALE_RST 8'h00
`define FRCR_RATE_MASK 8'h3f
`define FRCR_SCALE_MASK 8'h07
`define FRCR_ODR_F 3:0
`define FRCR_BWP_F 5:4
`define FRCR_RANGE_F 2:0
// ========================================
// codes and figures
`define FRCR_ODR_MIN 4'h6
`define FRCR_ODR_MAX 4'hd
`define FRCR_ODR_REF 4'h8
`define FRCR_ODR_BASE_HZ 12'h064
`define FRCR_BWP_MAX 2'h2
`define FRCR_RANGE_MAX 3'h4
`define FRCR_SENS_BASE 12'h0a4
`define FRCR_ERR_CFG 8'h02
`define FRCR_LEN_HDR 3'h7
`define FRCR_LEN_RAW 3'h6
`define FRCR_EMPTY_BYTE 8'h00
`endif

/* File: shared/frcr_pkg.sv */
// Purpose: shared types of the rate/FIFO register bank
// Assumes: nothing
// Notes: constants live in frcr_cfg.svh
package frcr_pkg;
	typedef logic [7:0] frcr_byte_t;
	// transaction state, one-hot
	typedef enum logic [1:0] {FRCR_IDLE = 2'b01, FRCR_XFER = 2'b10} frcr_xfer_t;
endpackage

/* File: shared/frcr_link_if.sv */
// Purpose: carrier between the core, the frame memory and the rate decoder
// Assumes: one clock
// Notes: no clocking block
`timescale 1ns/1ps
`default_nettype none
interface frcr_link_if #(parameter int AW = 7, parameter int WW = 57);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [AW-1:0] rd_addr;
	logic [WW-1:0] wr_data;
	logic [WW-1:0] rd_data;
	logic [7:0] rate_cfg;
	logic [2:0] range_code;
	logic [11:0] odr_hz;
	logic [11:0] sens_x10;
	logic cfg_legal;
	modport core(output wr_en, wr_addr, rd_addr, wr_data, rate_cfg, range_code,
		input rd_data, odr_hz, sens_x10, cfg_legal);
	modport mem(input wr_en, wr_addr, rd_addr, wr_data, output rd_data);
	modport calc(input rate_cfg, range_code, output odr_hz, sens_x10, cfg_legal);
endinterface
`default_nettype wire

/* File: hdl/frcr_frame_mem.sv */
// Purpose: frame store, one word per frame
// Assumes: single clock, read data one cycle after the address
// Notes: read during write of the same word returns the old word
`timescale 1ns/1ps
`default_nettype none
module frcr_frame_mem #(parameter int AW = 7, parameter int WW = 57) (
	input wire logic mclk,
	frcr_link_if.mem lk
);
	import frcr_pkg::*;
	logic [WW-1:0] mem_r [2**AW];
	logic [WW-1:0] rd_r;
	// ========================================
	// write port and registered read port
	always_ff @(posedge mclk)
	begin
		if (lk.wr_en)
		begin
			mem_r[lk.wr_addr] <= lk.wr_data;
		end
		rd_r <= mem_r[lk.rd_addr];
	end
	assign lk.rd_data = rd_r;
endmodule
`default_nettype wire

/* File: hdl/frcr_rate_calc.sv */
// Purpose: decode rate code, bandwidth legality and scale sensitivity
// Assumes: inputs from core registers, or from the byte being written in a rate/scale write cycle
// Notes: purely combinational, core registers the results
`timescale 1ns/1ps
`default_nettype none
`include "frcr_cfg.svh"
module frcr_rate_calc (
	frcr_link_if.calc lk
);
	import frcr_pkg::*;
	logic [3:0] odr;
	logic [1:0] bwp;
	assign odr = lk.rate_cfg[`FRCR_ODR_F];
	assign bwp = lk.rate_cfg[`FRCR_BWP_F];
	// ========================================
	// rate in hertz, legality, sensitivity in tenths of counts
	always_comb
	begin
		lk.cfg_legal = (odr >= `FRCR_ODR_MIN) && (odr <= `FRCR_ODR_MAX)
			&& (bwp <= `FRCR_BWP_MAX);
		if (odr < `FRCR_ODR_MIN || odr > `FRCR_ODR_MAX)
		begin
			lk.odr_hz = 12'h000; // reserved codes report no rate
		end
		else if (odr >= `FRCR_ODR_REF)
		begin
			lk.odr_hz = `FRCR_ODR_BASE_HZ << (odr - `FRCR_ODR_REF);
		end
		else
		begin
			lk.odr_hz = `FRCR_ODR_BASE_HZ >> (`FRCR_ODR_REF - odr);
		end
		if (lk.range_code > `FRCR_RANGE_MAX)
		begin
			lk.sens_x10 = 12'h000; // reserved range codes
		end
		else
		begin
			lk.sens_x10 = `FRCR_SENS_BASE << lk.range_code;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/frcr_regs.sv */
// Purpose: FIFO fill count, FIFO read port, rate/filter and scale registers
// Assumes: a serial engine on mclk delivers start/byte/end strobes
// Notes: byte reads at the FIFO port must be at least two cycles apart
// How it works
// - read-only register reports FIFO byte count
// - count includes skip and skipped frames
// - empty FIFO reads count zero
// - count zeroed on full readout or flush
// - count changes only per whole frame
// - burst address holds at FIFO read port
// - partial frame retransmitted whole at next readout
// - next frame only after current fully read
// - FIFO readout keeps new-data flag
// - byte layout follows selected frame format
// - rate register resets 0x28, odr/bandwidth fields
// - rate equals 100 over two-power (8-code)
// - rate independent of power mode
// - bandwidth field selects filter cutoff
// - undefined rate/bandwidth flags error code
// - three-bit range selects full scale
// - sensitivity 16.4 doubling per narrower range
// - range write keeps sample-ready flag
// - sample register read clears ready flag
`timescale 1ns/1ps
`default_nettype none
`include "frcr_cfg.svh"
module frcr_regs #(
	parameter int AW = 7,
	parameter logic [7:0] HDR_BYTE = 8'h01
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic xfer_start,
	input wire logic [7:0] xfer_addr,
	input wire logic byte_rd,
	input wire logic byte_wr,
	input wire frcr_pkg::frcr_byte_t byte_wdata,
	input wire logic xfer_end,
	input wire logic smp_valid,
	input wire logic [47:0] smp_data,
	input wire logic hdr_mode,
	input wire logic fifo_flush,
	input wire logic err_clr,
	output frcr_pkg::frcr_byte_t rd_data,
	output logic rd_valid,
	output logic [11:0] odr_hz,
	output logic [1:0] filt_bwp,
	output logic [2:0] range_code,
	output logic [11:0] sens_x10,
	output logic [7:0] err_code,
	output logic drdy
);
	import frcr_pkg::*;
	localparam int WW = 57;

	typedef struct packed {
		frcr_xfer_t xs;
		logic [7:0] addr;
		logic [AW:0] wp;
		logic [AW:0] rp;
		logic [2:0] idx;
		logic [15:0] cnt;
		logic [7:0] rate;
		logic [7:0] scale;
		logic [7:0] rdat;
		logic rval;
		logic [11:0] odr_hz;
		logic [11:0] sens;
		logic [7:0] err;
		logic drdy;
	} frcr_st_t;

	frcr_st_t st_r;
	frcr_st_t st_nxt;
	frcr_link_if #(.AW(AW), .WW(WW)) lk();

	logic [AW:0] frames;
	logic full;
	logic wr_rate;
	logic rd_fifo;
	logic [WW-1:0] word;
	logic [2:0] rlen;
	logic [2:0] wlen;
	logic [2:0] bsel;
	logic done;
	logic wr_scale;

	// ========================================
	// submodules
	frcr_frame_mem #(.AW(AW), .WW(WW)) u_mem (
		.mclk(mclk),
		.lk(lk.mem)
	);
	frcr_rate_calc u_calc (
		.lk(lk.calc)
	);

	// ========================================
	// frame bookkeeping
	assign frames = st_r.wp - st_r.rp;
	assign full = frames[AW];
	assign word = lk.rd_data;
	assign rlen = word[WW-1] ? `FRCR_LEN_HDR : `FRCR_LEN_RAW;
	assign wlen = hdr_mode ? `FRCR_LEN_HDR : `FRCR_LEN_RAW;
	// headerless frames skip byte 0 of the stored word
	assign bsel = word[WW-1] ? st_r.idx : st_r.idx + 3'h1;
	assign rd_fifo = byte_rd && st_r.xs == FRCR_XFER && st_r.addr == `FRCR_ADR_FIFO;
	assign done = rd_fifo && frames != '0 && st_r.idx == rlen - 3'h1;
	assign wr_rate = byte_wr && st_r.xs == FRCR_XFER && st_r.addr == `FRCR_ADR_RATE;
	assign wr_scale = byte_wr && st_r.xs == FRCR_XFER && st_r.addr == `FRCR_ADR_SCALE;

	// ========================================
	// memory and decoder hookup; decoder sees the value about to be stored
	assign lk.wr_en = smp_valid && !full && !fifo_flush;
	assign lk.wr_addr = st_r.wp[AW-1:0];
	assign lk.wr_data = {hdr_mode, smp_data, HDR_BYTE};
	assign lk.rd_addr = st_r.rp[AW-1:0];
	assign lk.rate_cfg = wr_rate ? (byte_wdata & `FRCR_RATE_MASK) : st_r.rate;
	// built from inputs and state, not the next state, so no loop through the decoder
	assign lk.range_code = wr_scale ? byte_wdata[`FRCR_RANGE_F] : st_r.scale[`FRCR_RANGE_F];

	// ========================================
	// next state
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rval = 1'b0;
		if (xfer_start)
		begin
			st_nxt.xs = FRCR_XFER;
			st_nxt.addr = xfer_addr;
		end
		if (byte_rd && st_r.xs == FRCR_XFER)
		begin
			st_nxt.rval = 1'b1;
			case (st_r.addr)
				`FRCR_ADR_CNT_LO: st_nxt.rdat = st_r.cnt[7:0];
				`FRCR_ADR_CNT_HI: st_nxt.rdat = {5'h00, st_r.cnt[10:8]};
				`FRCR_ADR_RATE: st_nxt.rdat = st_r.rate;
				`FRCR_ADR_SCALE: st_nxt.rdat = st_r.scale;
				`FRCR_ADR_FIFO:
				begin
					if (frames != '0)
					begin
						st_nxt.rdat = word[{bsel, 3'h0} +: 8];
						st_nxt.idx = st_r.idx + 3'h1;
					end
					else
					begin
						st_nxt.rdat = `FRCR_EMPTY_BYTE;
					end
				end
				default: st_nxt.rdat = 8'h00;
			endcase
			// sample registers live elsewhere, their read still clears the flag
			if (st_r.addr >= `FRCR_ADR_DATA_LO && st_r.addr <= `FRCR_ADR_DATA_HI)
			begin
				st_nxt.drdy = 1'b0;
			end
		end
		// count moves only on whole frames, never per byte
		if (done)
		begin
			st_nxt.idx = 3'h0;
			st_nxt.rp = st_r.rp + 1'b1;
			st_nxt.cnt = (frames == 1) ? 16'h0000 : st_r.cnt - 16'(rlen);
		end
		if (byte_wr && st_r.xs == FRCR_XFER)
		begin
			case (st_r.addr)
				`FRCR_ADR_RATE:
				begin
					st_nxt.rate = byte_wdata & `FRCR_RATE_MASK;
				end
				`FRCR_ADR_SCALE:
				begin
					st_nxt.scale = byte_wdata & `FRCR_SCALE_MASK;
				end
				default: st_nxt.scale = st_nxt.scale;
			endcase
		end
		// burst address steps, except at the FIFO port
		if ((byte_rd || byte_wr) && st_r.xs == FRCR_XFER && st_r.addr != `FRCR_ADR_FIFO)
		begin
			st_nxt.addr = st_r.addr + 8'h01;
		end
		if (xfer_end)
		begin
			st_nxt.xs = FRCR_IDLE;
			st_nxt.idx = 3'h0;
		end
		// a frame from the sensor; when full it is skipped but still counted
		if (smp_valid)
		begin
			st_nxt.cnt = st_nxt.cnt + 16'(wlen);
			if (!full)
			begin
				st_nxt.wp = st_r.wp + 1'b1;
			end
			st_nxt.drdy = 1'b1; // set beats a same-cycle clear
		end
		if (fifo_flush)
		begin
			st_nxt.rp = st_nxt.wp;
			st_nxt.cnt = 16'h0000;
			st_nxt.idx = 3'h0;
		end
		if (err_clr)
		begin
			st_nxt.err = 8'h00;
		end
		if (wr_rate && !lk.cfg_legal)
		begin
			st_nxt.err = `FRCR_ERR_CFG;
		end
		// rate holds no power-mode term at all
		st_nxt.odr_hz = lk.odr_hz;
		st_nxt.sens = lk.sens_x10;
	end

	// ========================================
	// state register
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			st_r <= '0;
			st_r.xs <= FRCR_IDLE;
			st_r.rate <= `FRCR_RATE_RST;
			st_r.scale <= `FRCR_SCALE_RST;
			st_r.odr_hz <= `FRCR_ODR_BASE_HZ;
			st_r.sens <= `FRCR_SENS_BASE;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ========================================
	// outputs straight from the state register
	assign rd_data = st_r.rdat;
	assign rd_valid = st_r.rval;
	assign odr_hz = st_r.odr_hz;
	assign filt_bwp = st_r.rate[`FRCR_BWP_F];
	assign range_code = st_r.scale[`FRCR_RANGE_F];
	assign sens_x10 = st_r.sens;
	assign err_code = st_r.err;
	assign drdy = st_r.drdy;

	// ========================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_count_when_empty: assert property (frames == '0 |-> st_r.cnt == 16'h0000)
		else $error("count nonzero with no frame stored");
	a_flush_clears: assert property (fifo_flush |=> st_r.cnt == 16'h0000)
		else $error("flush left count nonzero");
	a_count_per_frame: assert property ($changed(st_r.cnt) |->
		$past(smp_valid) || $past(done) || $past(fifo_flush))
		else $error("count moved without a frame event");
	a_burst_addr_hold: assert property (rd_fifo |=> st_r.addr == `FRCR_ADR_FIFO)
		else $error("address left the FIFO port in a burst");
	// pointer sum kept at pointer width so a wrap compares correctly
	a_partial_restart: assert property (xfer_end && !fifo_flush |=>
		st_r.idx == 3'h0 && st_r.rp == ($past(st_r.rp) + {{AW{1'b0}}, $past(done)}))
		else $error("partial frame not rewound");
	a_frame_whole: assert property ($changed(st_r.rp) && !$past(fifo_flush) |->
		$past(st_r.idx) == $past(rlen) - 3'h1)
		else $error("read pointer moved mid-frame");
	a_fifo_keeps_ready: assert property (rd_fifo && st_r.drdy |=> st_r.drdy)
		else $error("FIFO read cleared ready flag");
	// a reset antecedent would be disabled by the reset itself, so look just after it
	a_rate_reset: assert property ($fell(sys_rst) |->
		st_r.rate == `FRCR_RATE_RST && st_r.scale == `FRCR_SCALE_RST)
		else $error("rate register reset value wrong");
	a_rate_hertz: assert property (st_r.rate[`FRCR_ODR_F] == 4'h6 && !wr_rate
		&& $stable(st_r.rate) |=> st_r.odr_hz == 12'h019)
		else $error("code 6 does not give 25 Hz");
	a_bad_cfg_error: assert property (wr_rate && !err_clr &&
		(byte_wdata[`FRCR_BWP_F] == 2'h3 || byte_wdata[`FRCR_ODR_F] < 4'h6
		|| byte_wdata[`FRCR_ODR_F] > 4'hd) |=> st_r.err == `FRCR_ERR_CFG)
		else $error("illegal setting not flagged");
	a_sens_doubles: assert property ($stable(st_r.scale) && range_code < 3'h4 ##1
		$stable(st_r.scale) |-> sens_x10 == (`FRCR_SENS_BASE << range_code))
		else $error("sensitivity not doubling per range");
	a_range_keeps_ready: assert property (byte_wr && st_r.addr == `FRCR_ADR_SCALE
		&& st_r.drdy |=> st_r.drdy)
		else $error("range write cleared ready flag");
	a_sample_read_clear: assert property (byte_rd && st_r.xs == FRCR_XFER &&
		st_r.addr == `FRCR_ADR_DATA_LO && !smp_valid |=> !st_r.drdy)
		else $error("sample read left ready flag set");

	c_frame_read: cover property (done);
	c_skip_full: cover property (smp_valid && full);
	c_partial_end: cover property (xfer_end && st_r.idx != 3'h0);
	c_bad_cfg: cover property (wr_rate && !lk.cfg_legal);
endmodule
`default_nettype wire

/* File: tb/frcr_host.sv */
// Purpose: host side model of the register port
// Assumes: design answers one cycle after a byte strobe
// Notes: strobes are kept two cycles apart, the fastest legal pace
`timescale 1ns/1ps
`default_nettype none
module frcr_host (
	input wire logic mclk,
	output logic xfer_start,
	output logic [7:0] xfer_addr,
	output logic byte_rd,
	output logic byte_wr,
	output logic [7:0] byte_wdata,
	output logic xfer_end,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	bit tmo = 1'b0;
	// idle levels from time zero
	initial
	begin
		xfer_start = 1'b0;
		xfer_addr = 8'h00;
		byte_rd = 1'b0;
		byte_wr = 1'b0;
		byte_wdata = 8'h00;
		xfer_end = 1'b0;
	end
	// ========================================
	// transaction tasks
	// address is inverted once taken so a stale value never passes as valid
	task automatic start(input logic [7:0] a);
		@(posedge mclk);
		xfer_start <= 1'b1;
		xfer_addr <= a;
		@(posedge mclk);
		xfer_start <= 1'b0;
		xfer_addr <= ~a;
	endtask
	// one byte of a burst, same open transaction each time
	task automatic rd(output logic [7:0] d);
		int n;
		@(posedge mclk);
		byte_rd <= 1'b1;
		@(posedge mclk);
		byte_rd <= 1'b0;
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (rd_valid !== 1'b1 && n < 1); // answer must come exactly one cycle later
		tmo = tmo | (rd_valid !== 1'b1);
		d = rd_data;
	endtask
	task automatic wr(input logic [7:0] v);
		@(posedge mclk);
		byte_wr <= 1'b1;
		byte_wdata <= v;
		@(posedge mclk);
		byte_wr <= 1'b0;
		byte_wdata <= ~v;
	endtask
	task automatic stop();
		@(posedge mclk);
		xfer_end <= 1'b1;
		@(posedge mclk);
		xfer_end <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: tb/fifo_readout_rate_config_regs_tb.sv */
// Purpose: self-checking bench of the rate/FIFO register bank
// Assumes: small frame store (AW=3, eight frames) to reach overflow fast
// Notes: outputs are read well after the edge that changes them
`timescale 1ns/1ps
`default_nettype none
module fifo_readout_rate_config_regs_tb;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic smp_valid = 1'b0;
	logic [47:0] smp_data = 48'h0;
	logic hdr_mode = 1'b0;
	logic fifo_flush = 1'b0;
	logic err_clr = 1'b0;
	logic xfer_start, byte_rd, byte_wr, xfer_end, rd_valid, drdy;
	logic [7:0] xfer_addr, byte_wdata, rd_data, err_code, d;
	logic [11:0] odr_hz, sens_x10;
	logic [1:0] filt_bwp;
	logic [2:0] range_code;
	logic [7:0] bad [3] = '{8'h36, 8'h3d, 8'h38};
	int err_total = 0;
	int cmp_count = 0;
	int i;
	// free-running 10 MHz clock
	always #50 mclk = ~mclk;
	frcr_host host (.mclk(mclk), .xfer_start(xfer_start), .xfer_addr(xfer_addr),
		.byte_rd(byte_rd), .byte_wr(byte_wr), .byte_wdata(byte_wdata),
		.xfer_end(xfer_end), .rd_data(rd_data), .rd_valid(rd_valid));
	frcr_regs #(.AW(3)) dut (.mclk(mclk), .sys_rst(sys_rst), .xfer_start(xfer_start),
		.xfer_addr(xfer_addr), .byte_rd(byte_rd), .byte_wr(byte_wr),
		.byte_wdata(byte_wdata), .xfer_end(xfer_end), .smp_valid(smp_valid),
		.smp_data(smp_data), .hdr_mode(hdr_mode), .fifo_flush(fifo_flush),
		.err_clr(err_clr), .rd_data(rd_data), .rd_valid(rd_valid), .odr_hz(odr_hz),
		.filt_bwp(filt_bwp), .range_code(range_code), .sens_x10(sens_x10),
		.err_code(err_code), .drdy(drdy));
	// ========================================
	// report and compare
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// a missing answer ends the run at once
	task automatic rd1();
		host.rd(d);
		if (host.tmo)
		begin
			err_total++;
			summarize();
		end
	endtask
	// ========================================
	// access helpers
	task automatic rdb(input logic [7:0] a, input logic [7:0] exp);
		host.start(a);
		rd1();
		host.stop();
		chk(d, exp);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		host.start(a);
		host.wr(v);
		host.stop();
	endtask
	// low then high byte, address steps from 0x22 to 0x23
	task automatic cnt(input logic [15:0] exp);
		logic [7:0] lo;
		host.start(8'h22);
		rd1();
		lo = d;
		rd1();
		host.stop();
		chk({d, lo}, exp);
	endtask
	// n bytes of frame f from the read port; header byte first when h is set
	task automatic fburst(input logic [47:0] f, input int h, input int n);
		int k;
		host.start(8'h24);
		for (k = 0; k < n; k++)
		begin
			rd1();
			chk(d, (h == 1 && k == 0) ? 8'h01 : f[8*(k-h)+:8]);
		end
		host.stop();
	endtask
	task automatic push(input logic [47:0] f, input logic h);
		@(posedge mclk);
		smp_valid <= 1'b1;
		smp_data <= f;
		hdr_mode <= h;
		@(posedge mclk);
		smp_valid <= 1'b0;
	endtask
	// ========================================
	// main sequence
	initial
	begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		rdb(8'h42, 8'h28);
		rdb(8'h43, 8'h00);
		cnt(16'h0000);
		chk(odr_hz, 16'h0064);
		chk(sens_x10, 16'h00a4);
		chk(filt_bwp, 16'h0002);
		chk(err_code, 16'h0000);
		chk(drdy, 16'h0000);
		$display("test reset done");
		// every legal rate code, the host never asks for a reserved one here
		for (i = 6; i < 14; i++)
		begin
			wreg(8'h42, i[7:0]);
			chk(odr_hz, i < 8 ? 16'h0064 >> (8 - i) : 16'h0064 << (i - 8));
			chk(err_code, 16'h0000);
		end
		wreg(8'h42, 8'h18);
		chk(filt_bwp, 16'h0001);
		rdb(8'h42, 8'h18);
		// undefined bandwidth on legal rates, reserved rate codes never sent
		for (i = 0; i < 3; i++)
		begin
			@(posedge mclk);
			err_clr <= 1'b1;
			@(posedge mclk);
			err_clr <= 1'b0;
			@(negedge mclk);
			chk(err_code, 16'h0000);
			wreg(8'h42, bad[i]);
			chk(err_code, 16'h0002);
		end
		$display("test rate done");
		for (i = 0; i < 5; i++)
		begin
			wreg(8'h43, i[7:0]);
			chk(range_code, i[15:0]);
			chk(sens_x10, 16'h00a4 << i);
		end
		wreg(8'h43, 8'h05);
		chk(sens_x10, 16'h0000);
		$display("test range done");
		push(48'h060504030201, 1'b1);
		push(48'h161514131211, 1'b1);
		cnt(16'h000e);
		wreg(8'h43, 8'h01);
		chk(drdy, 16'h0001);
		fburst(48'h060504030201, 1, 3);
		cnt(16'h000e);
		fburst(48'h060504030201, 1, 7);
		cnt(16'h0007);
		fburst(48'h161514131211, 1, 7);
		cnt(16'h0000);
		chk(drdy, 16'h0001);
		rdb(8'h12, 8'h00);
		chk(drdy, 16'h0000);
		// nine headerless frames into an eight-frame store
		for (i = 0; i < 9; i++)
			push(48'h262524232221, 1'b0);
		fburst(48'h262524232221, 0, 2);
		wreg(8'h22, 8'hff);
		cnt(16'h0036);
		@(posedge mclk);
		fifo_flush <= 1'b1;
		@(posedge mclk);
		fifo_flush <= 1'b0;
		cnt(16'h0000);
		rdb(8'h24, 8'h00);
		$display("test fifo done");
		summarize();
	end
endmodule
`default_nettype wire
